// [rtl/dcw_decoder.sv]
// Overview of operation
// R01: After a multi-register write, reply address, function, start and count.
// R02: Command word at register 50000, setpoint at 50010, written by master.
// R03: State word at 50200 and output frequency at 50210, readable.
// R04: Alias area 02810/02811 and 02910/02911 mirrors the same four words.
// R05: Bits 01:00 pick one of four preset references.
// R06: Bit 02 low applies DC brake and stop; high allows ramping.
// R07: Bit 03 low coasts at once; high permits starting.
// R08: Bit 04 low ramps down on quick-stop ramp.
// R09: Bit 05 low freezes output; only speed-up/slow-down inputs change it.
// R10: While frozen, stop only via coast, DC brake, or inverse digital inputs.
// R11: Bit 06 low ramps to stop; high permits starting.
// R12: Trip reset only on rising edge of bit 07.
// R13: Bit 08 high selects jog speed.
// R14: Bit 09 selects ramp set one or two.
// R15: Whole command word ignored unless bit 10 is high.
// R16: Bit 11 drives relay one only when its function is option 36.
// R17: Bit 12 drives relay two only when its function is option 37.
// R18: Bit 13 selects set-up 1 or 2 only under multi set-up option 9.
// R19: Bit 15 reverses only with source bus, AND or OR.
// R20: Reference, coast, start, set-up bits combine with digital inputs per setting.
// R21: Layout applies only when protocol setting is zero.
// R22: Setpoint and frequency are signed percentages, 16384 equals 100 percent.
// R23: Master sends register number minus one on the wire.
// R24: Command bit 14 is ignored.
`default_nettype none
module dcw_decoder (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // Received frame bytes, same clock domain
    input  wire logic                 rx_valid,
    input  wire logic [7:0]           rx_byte,
    input  wire logic                 rx_end,
    input  wire logic [7:0]           slave_addr,
    // Reply bytes
    output logic                      tx_valid,
    output logic [7:0]                tx_byte,
    output logic                      tx_last,
    input  wire logic                 tx_ready,
    // Settings
    input  wire logic [7:0]           protocol_sel,
    input  wire logic [7:0]           relay1_fn,
    input  wire logic [7:0]           relay2_fn,
    input  wire logic [3:0]           active_setup,
    input  wire dcw_pkg::dcw_src_cfg_s src_cfg,
    // Digital input pins
    input  wire dcw_pkg::dcw_dig_s    dig_in,
    // Drive state and output frequency
    input  wire logic [15:0]          drive_state_word,
    input  wire logic signed [15:0]   output_frequency_value,
    // Actions toward the motor control
    output dcw_pkg::dcw_act_s         act,
    output logic signed [15:0]        speed_setpoint_q_out
);
    typedef enum logic [2:0] {
        ST_RX,
        ST_EXEC,
        ST_TX,
        ST_DROP
    } dcw_state_e;

    function automatic logic combine(input dcw_pkg::dcw_src_e s, input logic bus_b,
                                     input logic dig_b);
        case (s)
            dcw_pkg::SRC_DIGITAL: combine = dig_b;
            dcw_pkg::SRC_BUS:     combine = bus_b;
            dcw_pkg::SRC_AND:     combine = bus_b & dig_b;
            dcw_pkg::SRC_OR:      combine = bus_b | dig_b;
            default:              combine = dig_b;
        endcase
    endfunction

    // Register number on the wire is one less than the documented number
    // Hit flag in bit 2, register index below it
    function automatic logic [2:0] decode_reg(input logic [15:0] wire_addr);
        logic [15:0] num;
        num = wire_addr + 16'h0001; // R23
        if (num == dcw_pkg::REG_COMMAND_WORD || num == dcw_pkg::REG_COMMAND_ALIAS) begin
            decode_reg = 3'd4; // R02 R04
        end else if (num == dcw_pkg::REG_SPEED_SETPOINT ||
                     num == dcw_pkg::REG_SETPOINT_ALIAS) begin
            decode_reg = 3'd5;
        end else if (num == dcw_pkg::REG_DRIVE_STATE || num == dcw_pkg::REG_STATE_ALIAS) begin
            decode_reg = 3'd6; // R03 R04
        end else if (num == dcw_pkg::REG_OUTPUT_FREQUENCY ||
                     num == dcw_pkg::REG_FREQUENCY_ALIAS) begin
            decode_reg = 3'd7;
        end else begin
            decode_reg = 3'd0;
        end
    endfunction

    dcw_state_e       state_q;
    logic [7:0]       rxb_q [dcw_pkg::FRAME_BYTES_MAX];
    logic [4:0]       rx_cnt_q;
    logic [7:0]       txb_q [dcw_pkg::FRAME_BYTES_MAX];
    logic [4:0]       tx_len_q;
    logic [4:0]       tx_idx_q;
    logic [15:0]      command_q;
    logic [15:0]      setpoint_q;
    logic             reset_bit_q;
    dcw_pkg::dcw_act_s act_q;
    logic             tx_valid_q;
    logic [7:0]       tx_byte_q;
    logic             tx_last_q;
    logic [1:0]       dig_ref_m_q;
    logic [1:0]       dig_ref_q;
    logic [8:0]       dig_m_q;
    logic [8:0]       dig_q;

    // Request fields
    wire logic [7:0]  req_fn    = rxb_q[1];
    wire logic [15:0] req_addr  = {rxb_q[2], rxb_q[3]};
    wire logic [15:0] req_cnt   = {rxb_q[4], rxb_q[5]};
    wire logic [15:0] req_w1    = {rxb_q[7], rxb_q[8]};
    wire logic [15:0] req_w2    = {rxb_q[9], rxb_q[10]};
    wire logic [15:0] req_w06   = {rxb_q[4], rxb_q[5]};
    wire logic        for_us    = (rxb_q[0] == slave_addr) || (rxb_q[0] == 8'h00);
    wire logic        broadcast = (rxb_q[0] == 8'h00);

    wire logic [2:0] dec0   = decode_reg(req_addr);
    wire logic [2:0] dec1   = decode_reg(req_addr + 16'h0001);
    wire logic   hit0       = dec0[2];
    wire logic   hit1       = dec1[2];
    wire logic [1:0] idx0   = dec0[1:0];
    wire logic [1:0] idx1   = dec1[1:0];
    wire logic   two        = (req_cnt == 16'h0002);
    wire logic   cnt_ok     = (req_cnt == 16'h0001) || two;
    wire logic   range_ok   = hit0 && (!two || (hit1 && idx1 == idx0 + 2'd1));
    wire logic   write_ok   = range_ok && !idx0[1] && !(two && idx0[0]); // command, setpoint only

    function automatic logic [15:0] reg_value(input logic [1:0] i, input logic [15:0] cmd,
                                              input logic [15:0] sp, input logic [15:0] st,
                                              input logic [15:0] fr);
        case (i)
            2'd0:    reg_value = cmd;
            2'd1:    reg_value = sp;
            2'd2:    reg_value = st;
            default: reg_value = fr;
        endcase
    endfunction

    wire logic [15:0] rd0 = reg_value(idx0, command_q, setpoint_q, drive_state_word,
                                      output_frequency_value);
    wire logic [15:0] rd1 = reg_value(idx1, command_q, setpoint_q, drive_state_word,
                                      output_frequency_value);

    // Digital inputs from pins pass two flops
    wire logic [8:0] dig_raw = {dig_in.coast_n, dig_in.start, dig_in.setup, dig_in.reverse,
                                dig_in.dc_brake_n, dig_in.coast_reset_n, dig_in.speed_up,
                                dig_in.slow_down, 1'b0};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dig_m_q     <= 9'h000;
            dig_q       <= 9'h000;
            dig_ref_m_q <= 2'h0;
            dig_ref_q   <= 2'h0;
        end else begin
            dig_m_q     <= dig_raw;
            dig_q       <= dig_m_q;
            dig_ref_m_q <= dig_in.ref_sel;
            dig_ref_q   <= dig_ref_m_q;
        end
    end

    wire logic d_coast_n  = dig_q[8];
    wire logic d_start    = dig_q[7];
    wire logic d_setup    = dig_q[6];
    wire logic d_reverse  = dig_q[5];
    wire logic d_brake_n  = dig_q[4];
    wire logic d_creset_n = dig_q[3];
    wire logic d_up       = dig_q[2];
    wire logic d_down     = dig_q[1];

    // Command interpretation
    wire logic        native  = (protocol_sel == dcw_pkg::PROTO_NATIVE); // R21
    wire logic        valid   = native && command_q[dcw_pkg::BIT_VALID]; // R15
    wire logic [15:0] cw      = valid ? command_q : 16'h0000; // R24
    wire logic [1:0]  bus_ref = cw[dcw_pkg::BIT_REF_LSB +: 2];
    wire logic [1:0]  ref_idx = valid ? {combine(src_cfg.ref_sel, bus_ref[1], dig_ref_q[1]),
                                         combine(src_cfg.ref_sel, bus_ref[0], dig_ref_q[0])}
                                      : dig_ref_q; // R05 R20
    wire logic brake_cmd  = valid && !cw[dcw_pkg::BIT_DC_BRAKE]; // R06
    wire logic coast_ok   = valid ? combine(src_cfg.coast_sel, cw[dcw_pkg::BIT_COAST], d_coast_n)
                                  : d_coast_n; // R07 R20
    wire logic start_ok   = valid ? combine(src_cfg.start_sel, cw[dcw_pkg::BIT_START], d_start)
                                  : d_start; // R11 R20
    wire logic qstop_cmd  = valid && !cw[dcw_pkg::BIT_QSTOP]; // R08
    wire logic hold_cmd   = valid && !cw[dcw_pkg::BIT_HOLD]; // R09
    wire logic coast_all  = !coast_ok || !d_creset_n;
    wire logic brake_all  = brake_cmd || !d_brake_n;
    wire logic ramp_stop  = !start_ok || qstop_cmd;
    wire logic reset_edge = valid && cw[dcw_pkg::BIT_RESET] && !reset_bit_q; // R12
    wire logic multi      = (active_setup == dcw_pkg::SETUP_MULTI);
    wire logic setup_sel  = valid ? combine(src_cfg.setup_sel, cw[dcw_pkg::BIT_SETUP], d_setup)
                                  : d_setup;
    wire logic rev_bus    = (src_cfg.reverse_sel != dcw_pkg::SRC_DIGITAL); // R19
    wire logic reverse    = valid && rev_bus
                          ? combine(src_cfg.reverse_sel, cw[dcw_pkg::BIT_REVERSE], d_reverse)
                          : d_reverse;

    always_comb begin
        act_q = '0;
        act_q.preset_index = ref_idx;
        act_q.dc_brake     = brake_all; // R06 R10
        act_q.coast        = coast_all; // R07 R10
        act_q.freeze       = hold_cmd && !coast_all && !brake_all; // R09
        // While frozen only coast and brake may stop the drive
        act_q.quick_stop   = qstop_cmd && !act_q.freeze; // R10
        act_q.ramp_stop    = ramp_stop && !act_q.freeze; // R10 R11
        act_q.run          = !coast_all && !brake_all && (act_q.freeze || !ramp_stop);
        act_q.trip_reset   = reset_edge;
        act_q.jog          = cw[dcw_pkg::BIT_JOG]; // R13
        act_q.ramp_set2    = cw[dcw_pkg::BIT_RAMP2]; // R14
        act_q.relay1       = (relay1_fn == dcw_pkg::RELAY_FN_BIT11) && cw[dcw_pkg::BIT_RELAY1]; // R16
        act_q.relay2       = (relay2_fn == dcw_pkg::RELAY_FN_BIT12) && cw[dcw_pkg::BIT_RELAY2]; // R17
        act_q.setup2       = multi && setup_sel; // R18 R20
        act_q.reverse      = reverse;
        act_q.freeze_up    = act_q.freeze && d_up; // R09
        act_q.freeze_down  = act_q.freeze && d_down;
    end

    // Frame handling
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q     <= ST_RX;
            rx_cnt_q    <= 5'd0;
            tx_len_q    <= 5'd0;
            tx_idx_q    <= 5'd0;
            command_q   <= dcw_pkg::COMMAND_RESET;
            setpoint_q  <= dcw_pkg::SETPOINT_RESET;
            reset_bit_q <= 1'b0;
            act         <= '0;
            tx_valid_q  <= 1'b0;
            tx_byte_q   <= 8'h00;
            tx_last_q   <= 1'b0;
            for (int i = 0; i < dcw_pkg::FRAME_BYTES_MAX; i++) begin
                rxb_q[i] <= 8'h00;
                txb_q[i] <= 8'h00;
            end
        end else begin
            act         <= act_q;
            reset_bit_q <= valid && cw[dcw_pkg::BIT_RESET]; // R12
            case (state_q)
                ST_RX: begin
                    if (rx_valid && rx_cnt_q < 5'(dcw_pkg::FRAME_BYTES_MAX)) begin
                        rxb_q[rx_cnt_q[3:0]] <= rx_byte;
                        rx_cnt_q <= rx_cnt_q + 5'd1;
                    end
                    if (rx_end) begin
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    rx_cnt_q <= 5'd0;
                    txb_q[0] <= rxb_q[0];
                    txb_q[1] <= req_fn;
                    tx_idx_q <= 5'd0;
                    state_q  <= (for_us && !broadcast) ? ST_TX : ST_DROP;
                    if (!for_us) begin
                        state_q <= ST_DROP;
                    end else if (req_fn == dcw_pkg::FN_READ_HOLDING && cnt_ok && range_ok) begin
                        txb_q[2] <= two ? 8'h04 : 8'h02; // R03
                        txb_q[3] <= rd0[15:8];
                        txb_q[4] <= rd0[7:0];
                        txb_q[5] <= rd1[15:8];
                        txb_q[6] <= rd1[7:0];
                        tx_len_q <= two ? 5'd7 : 5'd5;
                    end else if (req_fn == dcw_pkg::FN_WRITE_SINGLE && hit0 && !idx0[1]) begin
                        if (idx0[0]) setpoint_q <= req_w06; // R02 R22
                        else         command_q  <= req_w06;
                        for (int i = 2; i < 6; i++) txb_q[i] <= rxb_q[i];
                        tx_len_q <= 5'd6;
                    end else if (req_fn == dcw_pkg::FN_WRITE_MULTI && cnt_ok && write_ok &&
                                 rxb_q[6] == {req_cnt[6:0], 1'b0}) begin
                        if (idx0 == 2'd0) command_q  <= req_w1; // R02
                        else              setpoint_q <= req_w1;
                        if (two)          setpoint_q <= req_w2;
                        for (int i = 2; i < 6; i++) txb_q[i] <= rxb_q[i]; // R01
                        tx_len_q <= 5'd6;
                    end else begin
                        txb_q[1] <= req_fn | dcw_pkg::FN_EXCEPTION;
                        txb_q[2] <= (req_fn == dcw_pkg::FN_READ_HOLDING ||
                                     req_fn == dcw_pkg::FN_WRITE_SINGLE ||
                                     req_fn == dcw_pkg::FN_WRITE_MULTI)
                                    ? dcw_pkg::EXC_BAD_ADDRESS : dcw_pkg::EXC_BAD_FUNCTION;
                        tx_len_q <= 5'd3;
                    end
                end
                ST_TX: begin
                    if (!tx_valid_q || tx_ready) begin
                        if (tx_idx_q < tx_len_q) begin
                            tx_valid_q <= 1'b1;
                            tx_byte_q  <= txb_q[tx_idx_q[3:0]];
                            tx_last_q  <= (tx_idx_q == tx_len_q - 5'd1);
                            tx_idx_q   <= tx_idx_q + 5'd1;
                        end else begin
                            tx_valid_q <= 1'b0;
                            tx_last_q  <= 1'b0;
                            state_q    <= ST_RX;
                        end
                    end
                end
                ST_DROP: begin
                    state_q <= ST_RX;
                end
                default: begin
                    state_q <= ST_RX;
                end
            endcase
        end
    end

    assign tx_valid             = tx_valid_q;
    assign tx_byte              = tx_byte_q;
    assign tx_last              = tx_last_q;
    assign speed_setpoint_q_out = setpoint_q;
endmodule
`default_nettype wire

// [rtl/dcw_pkg.sv]
`default_nettype none
package dcw_pkg;
    // Holding register numbers as counted by the master
    localparam logic [15:0] REG_COMMAND_WORD     = 16'hc350;
    localparam logic [15:0] REG_SPEED_SETPOINT   = 16'hc35a;
    localparam logic [15:0] REG_DRIVE_STATE      = 16'hc418;
    localparam logic [15:0] REG_OUTPUT_FREQUENCY = 16'hc422;
    localparam logic [15:0] REG_COMMAND_ALIAS    = 16'h0afa;
    localparam logic [15:0] REG_SETPOINT_ALIAS   = 16'h0afb;
    localparam logic [15:0] REG_STATE_ALIAS      = 16'h0b5e;
    localparam logic [15:0] REG_FREQUENCY_ALIAS  = 16'h0b5f;
    // Function codes
    localparam logic [7:0] FN_READ_HOLDING  = 8'h03;
    localparam logic [7:0] FN_WRITE_SINGLE  = 8'h06;
    localparam logic [7:0] FN_WRITE_MULTI   = 8'h10;
    localparam logic [7:0] FN_EXCEPTION     = 8'h80;
    localparam logic [7:0] EXC_BAD_FUNCTION = 8'h01;
    localparam logic [7:0] EXC_BAD_ADDRESS  = 8'h02;
    // Command word bit positions
    localparam int BIT_REF_LSB   = 0;
    localparam int BIT_DC_BRAKE  = 2;
    localparam int BIT_COAST     = 3;
    localparam int BIT_QSTOP     = 4;
    localparam int BIT_HOLD      = 5;
    localparam int BIT_START     = 6;
    localparam int BIT_RESET     = 7;
    localparam int BIT_JOG       = 8;
    localparam int BIT_RAMP2     = 9;
    localparam int BIT_VALID     = 10;
    localparam int BIT_RELAY1    = 11;
    localparam int BIT_RELAY2    = 12;
    localparam int BIT_SETUP     = 13;
    localparam int BIT_REVERSE   = 15;
    // Setting values
    localparam logic [7:0] PROTO_NATIVE      = 8'h00;
    localparam logic [7:0] RELAY_FN_BIT11    = 8'h24;
    localparam logic [7:0] RELAY_FN_BIT12    = 8'h25;
    localparam logic [3:0] SETUP_MULTI       = 4'h9;
    localparam logic [15:0] FULL_SCALE       = 16'h4000;
    // Reset values
    localparam logic [15:0] COMMAND_RESET    = 16'h0000;
    localparam logic [15:0] SETPOINT_RESET   = 16'h0000;
    localparam int FRAME_BYTES_MAX           = 16;

    typedef enum logic [1:0] {
        SRC_DIGITAL,
        SRC_BUS,
        SRC_AND,
        SRC_OR
    } dcw_src_e;

    // Per-function source selection settings
    typedef struct packed {
        dcw_src_e ref_sel;
        dcw_src_e coast_sel;
        dcw_src_e start_sel;
        dcw_src_e setup_sel;
        dcw_src_e reverse_sel;
    } dcw_src_cfg_s;

    // Digital input functions as delivered, active high except the active-low coast_n, dc_brake_n, coast_reset_n
    typedef struct packed {
        logic [1:0] ref_sel;
        logic       coast_n;
        logic       start;
        logic       setup;
        logic       reverse;
        logic       dc_brake_n;
        logic       coast_reset_n;
        logic       speed_up;
        logic       slow_down;
    } dcw_dig_s;

    // Motor action outputs
    typedef struct packed {
        logic [1:0] preset_index;
        logic       dc_brake;
        logic       coast;
        logic       quick_stop;
        logic       freeze;
        logic       ramp_stop;
        logic       run;
        logic       trip_reset;
        logic       jog;
        logic       ramp_set2;
        logic       relay1;
        logic       relay2;
        logic       setup2;
        logic       reverse;
        logic       freeze_up;
        logic       freeze_down;
    } dcw_act_s;
endpackage
`default_nettype wire

// [dv/dcw_decoder_sva.sv]
`default_nettype none
module dcw_decoder_sva (
    // Clock and reset
    input wire logic              clk,
    input wire logic              nrst,
    // Frame and reply streams
    input wire logic              rx_valid,
    input wire logic [7:0]        rx_byte,
    input wire logic              rx_end,
    input wire logic [7:0]        slave_addr,
    input wire logic              tx_valid,
    input wire logic [7:0]        tx_byte,
    input wire logic              tx_last,
    input wire logic              tx_ready,
    // Settings and actions
    input wire logic [7:0]        relay1_fn,
    input wire logic [7:0]        relay2_fn,
    input wire dcw_pkg::dcw_act_s act
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] addr_q;
    logic       in_frame_q;
    logic       first_q;

    // Address byte of the frame in flight, and start of a reply
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            addr_q <= 8'h00;
            in_frame_q <= 1'b0;
            first_q <= 1'b1;
        end else begin
            if (rx_valid && !in_frame_q) addr_q <= rx_byte;
            in_frame_q <= (in_frame_q || rx_valid) && !rx_end;
            if (tx_valid && tx_ready) first_q <= tx_last;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_ours_done;
        rx_end && addr_q == slave_addr;
    endsequence
    sequence s_reply_start;
        ##[2:5] tx_valid;
    endsequence

    property p_reply;
        s_ours_done |-> s_reply_start;
    endproperty
    property p_no_reply;
        rx_end && addr_q != slave_addr && addr_q != 8'h00 |-> !tx_valid [*8];
    endproperty
    property p_first_byte;
        tx_valid && first_q |-> tx_byte == slave_addr;
    endproperty
    property p_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte) && $stable(tx_last);
    endproperty
    property p_last;
        tx_last |-> tx_valid;
    endproperty
    property p_trip_pulse;
        act.trip_reset |=> !act.trip_reset;
    endproperty
    property p_relay1;
        act.relay1 |-> relay1_fn == dcw_pkg::RELAY_FN_BIT11
            || $past(relay1_fn) == dcw_pkg::RELAY_FN_BIT11
            || $past(relay1_fn, 2) == dcw_pkg::RELAY_FN_BIT11;
    endproperty
    property p_relay2;
        act.relay2 |-> relay2_fn == dcw_pkg::RELAY_FN_BIT12
            || $past(relay2_fn) == dcw_pkg::RELAY_FN_BIT12
            || $past(relay2_fn, 2) == dcw_pkg::RELAY_FN_BIT12;
    endproperty

    a_reply: assert property (p_reply) else $error("no reply after frame");
    a_no_reply: assert property (p_no_reply) else $error("reply to other address");
    a_first_byte: assert property (p_first_byte) else $error("reply not led by address");
    a_hold: assert property (p_hold) else $error("reply byte moved while stalled");
    a_last: assert property (p_last) else $error("last flag without valid");
    a_trip_pulse: assert property (p_trip_pulse) else $error("trip reset too long");
    a_relay1: assert property (p_relay1) else $error("relay one not gated");
    a_relay2: assert property (p_relay2) else $error("relay two not gated");
endmodule

bind dcw_decoder dcw_decoder_sva u_sva (
    .clk(clk), .nrst(nrst), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_end(rx_end),
    .slave_addr(slave_addr), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last),
    .tx_ready(tx_ready), .relay1_fn(relay1_fn), .relay2_fn(relay2_fn), .act(act)
);
`default_nettype wire

// [dv/dcw_master_model.sv]
`default_nettype none
module dcw_master_model (
    // Clock
    input  wire logic       clk,
    // Frame toward the block
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    output logic            rx_end,
    // Reply from the block
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_last,
    output logic            tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] rsp_q[$];
    logic       slow;

    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        rx_end = 1'b0;
        tx_ready = 1'b0;
        slow = 1'b0;
    end

    // Slow mode drops ready on every other cycle
    always @(posedge clk) begin
        if (tx_valid && tx_ready) rsp_q.push_back(tx_byte);
        tx_ready <= slow ? !tx_ready : 1'b1;
    end

    // Frame is sent whole, then the reply is awaited before the next one
    task automatic xfer(input logic [7:0] req[$], input int n);
        int k;
        rsp_q.delete();
        foreach (req[i]) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_byte <= req[i];
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_byte <= ~req[req.size()-1];
        rx_end <= 1'b1;
        @(posedge clk);
        rx_end <= 1'b0;
        k = 0;
        while (rsp_q.size() < n && k < 60) begin
            @(posedge clk);
            k++;
        end
        repeat (10) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// [dv/drive_control_word_decoder_tb.sv]
`default_nettype none
module drive_control_word_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed { logic [15:0] cmd; logic [12:0] exp; } dcw_row_s;

    logic clk = 1'b0, nrst, rx_valid, rx_end, tx_valid, tx_last, tx_ready;
    logic [7:0] rx_byte, tx_byte, slave_addr, protocol_sel, relay1_fn, relay2_fn;
    logic [3:0] active_setup;
    logic [15:0] drive_state_word, trips;
    logic signed [15:0] output_frequency_value, speed_setpoint_q_out;
    dcw_pkg::dcw_src_cfg_s src_cfg;
    dcw_pkg::dcw_dig_s dig_in;
    dcw_pkg::dcw_act_s act;
    int errors = 0, compares = 0, cycles = 0;
    dcw_row_s rows [4] = '{'{16'h047c, 13'h0000}, '{16'hbf7d, 13'h083f},
                           '{16'h0402, 13'h1740}, '{16'h4403, 13'h1f40}};

    always #10 clk = ~clk;

    dcw_decoder dut (.clk(clk), .nrst(nrst), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .rx_end(rx_end), .slave_addr(slave_addr), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .tx_last(tx_last), .tx_ready(tx_ready), .protocol_sel(protocol_sel),
        .relay1_fn(relay1_fn), .relay2_fn(relay2_fn), .active_setup(active_setup),
        .src_cfg(src_cfg), .dig_in(dig_in), .drive_state_word(drive_state_word),
        .output_frequency_value(output_frequency_value), .act(act),
        .speed_setpoint_q_out(speed_setpoint_q_out));
    dcw_master_model m (.clk(clk), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_end(rx_end),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last), .tx_ready(tx_ready));

    always @(posedge clk) begin
        trips <= trips + 16'(act.trip_reset === 1'b1);
        cycles++;
        if (cycles == 5000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic frm(input logic [7:0] req[$], input logic [7:0] exp[$]);
        m.xfer(req, exp.size());
        chk(16'(m.rsp_q.size()), 16'(exp.size()));
        foreach (exp[i]) chk({8'h00, m.rsp_q[i]}, {8'h00, exp[i]});
    endtask

    // Command write to the primary area, wire address one below the number
    task automatic wr_cmd(input logic [15:0] c);
        frm('{8'h01, 8'h10, 8'hc3, 8'h4f, 8'h00, 8'h01, 8'h02, c[15:8], c[7:0]},
            '{8'h01, 8'h10, 8'hc3, 8'h4f, 8'h00, 8'h01});
    endtask

    function automatic logic [12:0] pk(input dcw_pkg::dcw_act_s a);
        return {a.preset_index, a.dc_brake, a.coast, a.quick_stop, a.freeze, a.ramp_stop,
                a.jog, a.ramp_set2, a.relay1, a.relay2, a.setup2, a.reverse};
    endfunction

    task automatic wrap_up();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        nrst = 1'b0;
        trips = 16'h0000;
        slave_addr = 8'h01;
        protocol_sel = dcw_pkg::PROTO_NATIVE;
        relay1_fn = dcw_pkg::RELAY_FN_BIT11;
        relay2_fn = dcw_pkg::RELAY_FN_BIT12;
        active_setup = dcw_pkg::SETUP_MULTI;
        src_cfg = '{default: dcw_pkg::SRC_BUS};
        dig_in = '{coast_n: 1'b1, dc_brake_n: 1'b1, coast_reset_n: 1'b1, default: '0};
        drive_state_word = 16'h1234;
        output_frequency_value = 16'hc000;
        repeat (5) @(posedge clk);
        chk(16'(pk(act)), 16'h0000);
        chk({15'h0000, tx_valid}, 16'h0000);
        nrst <= 1'b1;
        repeat (4) @(negedge clk);
        chk(16'(pk(act)), 16'h0040);
        foreach (rows[i]) begin
            m.slow = i[0];
            wr_cmd(rows[i].cmd);
            chk(16'(pk(act)), 16'(rows[i].exp));
        end
        wr_cmd(16'h0002);
        chk(16'(pk(act)), 16'h0040);
        wr_cmd(16'h0480);
        chk(trips, 16'h0001);
        wr_cmd(16'h0480);
        chk(trips, 16'h0001);
        relay1_fn <= 8'h00;
        active_setup <= 4'h0;
        src_cfg.reverse_sel <= dcw_pkg::SRC_DIGITAL;
        wr_cmd(16'hbf7d);
        chk(16'(pk(act)), 16'h0834);
        chk({15'h0000, act.run}, 16'h0001);
        frm('{8'h01, 8'h03, 8'h0b, 8'h5d, 8'h00, 8'h02},
            '{8'h01, 8'h03, 8'h04, 8'h12, 8'h34, 8'hc0, 8'h00});
        frm('{8'h01, 8'h03, 8'hc4, 8'h21, 8'h00, 8'h01},
            '{8'h01, 8'h03, 8'h02, 8'hc0, 8'h00});
        frm('{8'h01, 8'h06, 8'h0a, 8'hfa, 8'h40, 8'h00},
            '{8'h01, 8'h06, 8'h0a, 8'hfa, 8'h40, 8'h00});
        chk(speed_setpoint_q_out, dcw_pkg::FULL_SCALE);
        frm('{8'h01, 8'h10, 8'h0a, 8'hf9, 8'h00, 8'h02, 8'h04, 8'h04, 8'h7c, 8'hc0, 8'h00},
            '{8'h01, 8'h10, 8'h0a, 8'hf9, 8'h00, 8'h02});
        chk(speed_setpoint_q_out, 16'hc000);
        frm('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h01, 8'h83, 8'h02});
        frm('{8'h01, 8'h07, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h01, 8'h87, 8'h01});
        frm('{8'h05, 8'h03, 8'hc4, 8'h17, 8'h00, 8'h01}, '{});
        wrap_up();
    end
endmodule
`default_nettype wire
